//--- logic/can_rx_flag_irq_enable.v
// Purpose: Receiver event flags, interrupt enables and request outputs of a CAN controller.
// Assumes: All inputs but the asynchronous resetn are synchronous to clk_sys; the engine keeps error counters itself.
// Notes: Registers sit on a plain strobe port with read data one cycle after the strobe.
`include "can_rx_flags_defs.vh"
`default_nettype none

module can_rx_flag_irq_enable (
   input wire clk_sys,
   input wire resetn,
   input wire [`REG_ADDR_MSB:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   input wire init_request,
   input wire init_acknowledge,
   input wire fifo_pending,
   output wire fifo_shift,
   output wire buffer_release,
   input wire overrun_event,
   input wire wakeup_event,
   input wire [8:0] rx_err_count,
   input wire [8:0] tx_err_count,
   output wire rx_request,
   output wire error_request,
   output wire wakeup_request,
   output wire irq
);

   // Initialization mode and the write window are two different conditions.
   // Writes are refused during the handshake too, not only once it is complete.
   wire init_mode;
   wire write_open;
   assign init_mode = init_request & init_acknowledge;
   assign write_open = ~init_request & ~init_acknowledge;

   // Decoded write strobes.
   wire wr_flags;
   wire wr_enables;
   assign wr_flags = reg_wr & write_open & (reg_addr == `REG_FLAGS_ADDR);
   assign wr_enables = reg_wr & write_open & (reg_addr == `REG_ENABLES_ADDR);

   // Flag registers.
   reg wakeup_flag_r;
   reg wakeup_flag_nxt;
   reg status_change_flag_r;
   reg status_change_flag_nxt;
   reg overrun_flag_r;
   reg overrun_flag_nxt;
   reg receive_full_flag_r;
   reg receive_full_flag_nxt;

   // Reported state codes.
   reg [1:0] rx_state_code_r;
   reg [1:0] rx_state_code_nxt;
   reg [1:0] tx_state_code_r;
   reg [1:0] tx_state_code_nxt;

   // Enable register fields.
   reg wakeup_irq_enable_r;
   reg status_change_irq_enable_r;
   reg [1:0] rx_state_sensitivity_r;
   reg [1:0] tx_state_sensitivity_r;
   reg overrun_irq_enable_r;
   reg receive_full_irq_enable_r;

   // Bus-off history for the receiver jump back to the error-free state.
   reg tx_busoff_r;

   // Foreground buffer handshake: one shift per clear, never while full.
   assign fifo_shift = fifo_pending & ~receive_full_flag_r & ~init_mode;

   // A one written to a set receive-full flag hands the buffer back.
   assign buffer_release = wr_flags & reg_wdata[`BIT_RXFULL] & receive_full_flag_r;

   // Actual transmitter state from its counter.
   reg [1:0] tx_actual;
   always @* begin
      if (tx_err_count > `ERR_BUSOFF_LIMIT) begin
         tx_actual = `CODE_BUSOFF;
      end else if (tx_err_count > `ERR_PASSIVE_LIMIT) begin
         tx_actual = `CODE_PASSIVE;
      end else if (tx_err_count > `ERR_WARN_LIMIT) begin
         tx_actual = `CODE_WARN;
      end else begin
         tx_actual = `CODE_OK;
      end
   end

   // Actual receiver state; bus-off is mirrored from the transmitter.
   // The receiver counter may still be high when bus-off ends, so the exit cycle
   // forces the error-free code instead of following the counter.
   wire tx_busoff_now;
   assign tx_busoff_now = (tx_actual == `CODE_BUSOFF);
   reg [1:0] rx_actual;
   always @* begin
      if (tx_busoff_now) begin
         rx_actual = `CODE_BUSOFF;
      end else if (tx_busoff_r) begin
         rx_actual = `CODE_OK;
      end else if (rx_err_count > `ERR_PASSIVE_LIMIT) begin
         rx_actual = `CODE_PASSIVE;
      end else if (rx_err_count > `ERR_WARN_LIMIT) begin
         rx_actual = `CODE_WARN;
      end else begin
         rx_actual = `CODE_OK;
      end
   end

   // Decides whether a move from old to new counts under a sensitivity choice.
   function qualifies;
      input [1:0] sens;
      input [1:0] old_code;
      input [1:0] new_code;
      reg busoff_edge;
      reg passive_edge;
      begin
         busoff_edge = (old_code == `CODE_BUSOFF) | (new_code == `CODE_BUSOFF);
         passive_edge = busoff_edge | (old_code == `CODE_PASSIVE) |
                        (new_code == `CODE_PASSIVE);
         case (sens)
            `SENS_NONE: qualifies = 1'b0;
            `SENS_BUSOFF: qualifies = busoff_edge;
            `SENS_PASSIVE: qualifies = passive_edge;
            `SENS_ALL: qualifies = 1'b1;
            default: qualifies = 1'b0;
         endcase
      end
   endfunction

   // Codes follow the actual states only while no status change is pending,
   // so software always sees the state that raised the interrupt it serves.
   wire code_update;
   wire rx_moves;
   wire tx_moves;
   wire status_event;
   assign code_update = ~status_change_flag_r;
   assign rx_moves = code_update & (rx_actual != rx_state_code_r);
   assign tx_moves = code_update & (tx_actual != tx_state_code_r);
   assign status_event =
      (rx_moves & qualifies(rx_state_sensitivity_r, rx_state_code_r, rx_actual)) |
      (tx_moves & qualifies(tx_state_sensitivity_r, tx_state_code_r, tx_actual));

   // State codes: read-only and untouched by initialization mode.
   always @* begin
      rx_state_code_nxt = rx_state_code_r;
      tx_state_code_nxt = tx_state_code_r;
      if (code_update) begin
         rx_state_code_nxt = rx_actual;
         tx_state_code_nxt = tx_actual;
      end
   end

   // Write-one-to-clear masks.
   wire clr_wakeup;
   wire clr_status;
   wire clr_overrun;
   wire clr_rxfull;
   assign clr_wakeup = wr_flags & reg_wdata[`BIT_WAKEUP];
   assign clr_status = wr_flags & reg_wdata[`BIT_STATUS];
   assign clr_overrun = wr_flags & reg_wdata[`BIT_OVERRUN];
   assign clr_rxfull = wr_flags & reg_wdata[`BIT_RXFULL];

   // Flag next values: a setting condition in the clear cycle keeps the flag set.
   always @* begin
      wakeup_flag_nxt = wakeup_flag_r;
      status_change_flag_nxt = status_change_flag_r;
      overrun_flag_nxt = overrun_flag_r;
      receive_full_flag_nxt = receive_full_flag_r;
      if (init_mode) begin
         wakeup_flag_nxt = 1'b0;
         status_change_flag_nxt = 1'b0;
         overrun_flag_nxt = 1'b0;
         receive_full_flag_nxt = 1'b0;
      end else begin
         if (clr_wakeup) begin
            wakeup_flag_nxt = 1'b0;
         end
         if (wakeup_event) begin
            wakeup_flag_nxt = 1'b1;
         end
         if (clr_status) begin
            status_change_flag_nxt = 1'b0;
         end
         if (status_event) begin
            status_change_flag_nxt = 1'b1;
         end
         if (clr_overrun) begin
            overrun_flag_nxt = 1'b0;
         end
         if (overrun_event) begin
            overrun_flag_nxt = 1'b1;
         end
         if (clr_rxfull) begin
            receive_full_flag_nxt = 1'b0;
         end
         if (fifo_shift) begin
            receive_full_flag_nxt = 1'b1;
         end
      end
   end

   // Flag registers; initialization mode holds them in their reset state.
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wakeup_flag_r <= 1'b0;
         status_change_flag_r <= 1'b0;
         overrun_flag_r <= 1'b0;
         receive_full_flag_r <= 1'b0;
      end else begin
         wakeup_flag_r <= wakeup_flag_nxt;
         status_change_flag_r <= status_change_flag_nxt;
         overrun_flag_r <= overrun_flag_nxt;
         receive_full_flag_r <= receive_full_flag_nxt;
      end
   end

   // State codes and bus-off history run through initialization mode.
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rx_state_code_r <= `CODE_OK;
         tx_state_code_r <= `CODE_OK;
         tx_busoff_r <= 1'b0;
      end else begin
         rx_state_code_r <= rx_state_code_nxt;
         tx_state_code_r <= tx_state_code_nxt;
         tx_busoff_r <= tx_busoff_now;
      end
   end

   // Event enables: cleared in initialization mode, written only outside it.
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wakeup_irq_enable_r <= 1'b0;
         status_change_irq_enable_r <= 1'b0;
         overrun_irq_enable_r <= 1'b0;
         receive_full_irq_enable_r <= 1'b0;
      end else if (init_mode) begin
         wakeup_irq_enable_r <= 1'b0;
         status_change_irq_enable_r <= 1'b0;
         overrun_irq_enable_r <= 1'b0;
         receive_full_irq_enable_r <= 1'b0;
      end else if (wr_enables) begin
         wakeup_irq_enable_r <= reg_wdata[`BIT_WAKEUP];
         status_change_irq_enable_r <= reg_wdata[`BIT_STATUS];
         overrun_irq_enable_r <= reg_wdata[`BIT_OVERRUN];
         receive_full_irq_enable_r <= reg_wdata[`BIT_RXFULL];
      end
   end

   // Sensitivity fields survive initialization mode, so a reconfiguration
   // does not silently change which bus state changes are reported.
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rx_state_sensitivity_r <= `SENS_NONE;
         tx_state_sensitivity_r <= `SENS_NONE;
      end else if (wr_enables) begin
         rx_state_sensitivity_r <= reg_wdata[`FLD_RX_HI:`FLD_RX_LO];
         tx_state_sensitivity_r <= reg_wdata[`FLD_TX_HI:`FLD_TX_LO];
      end
   end

   // Level requests, each gated by its enable.
   assign rx_request = receive_full_flag_r & receive_full_irq_enable_r;
   assign error_request = (overrun_flag_r & overrun_irq_enable_r) |
                          (status_change_flag_r & status_change_irq_enable_r);
   assign wakeup_request = wakeup_flag_r & wakeup_irq_enable_r;
   assign irq = rx_request | error_request | wakeup_request;

   // Register images.
   wire [7:0] flags_image;
   wire [7:0] enables_image;
   assign flags_image = {wakeup_flag_r, status_change_flag_r, rx_state_code_r,
                         tx_state_code_r, overrun_flag_r, receive_full_flag_r};
   assign enables_image = {wakeup_irq_enable_r, status_change_irq_enable_r,
                           rx_state_sensitivity_r, tx_state_sensitivity_r,
                           overrun_irq_enable_r, receive_full_irq_enable_r};

   // Read data stand only in the cycle after the strobe; reads never change state.
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= `REG_ZERO;
      end else if (reg_rd) begin
         case (reg_addr)
            `REG_FLAGS_ADDR: reg_rdata <= flags_image;
            `REG_ENABLES_ADDR: reg_rdata <= enables_image;
            default: reg_rdata <= `REG_ZERO;
         endcase
      end else begin
         reg_rdata <= `REG_ZERO;
      end
   end

endmodule // can_rx_flag_irq_enable

`default_nettype wire

//--- shared/can_rx_flags_defs.vh
// Purpose: Constants for the receiver flag and interrupt enable block.
// Assumes: Eight-bit registers on a plain strobe port, one module clock.
// Notes: Every offset, field position, code and limit used in the logic is named here.
`ifndef CAN_RX_FLAGS_DEFS_VH
`define CAN_RX_FLAGS_DEFS_VH

// Register port.
`define REG_ADDR_W 4
`define REG_ADDR_MSB 3
`define REG_FLAGS_ADDR 4'h0
`define REG_ENABLES_ADDR 4'h1
`define REG_ZERO 8'h00

// Field positions shared by the flag and enable registers.
`define BIT_WAKEUP 7
`define BIT_STATUS 6
`define FLD_RX_HI 5
`define FLD_RX_LO 4
`define FLD_TX_HI 3
`define FLD_TX_LO 2
`define BIT_OVERRUN 1
`define BIT_RXFULL 0

// Error state codes.
`define CODE_OK 2'h0
`define CODE_WARN 2'h1
`define CODE_PASSIVE 2'h2
`define CODE_BUSOFF 2'h3

// Sensitivity selections.
`define SENS_NONE 2'h0
`define SENS_BUSOFF 2'h1
`define SENS_PASSIVE 2'h2
`define SENS_ALL 2'h3

// Error counter limits.
`define ERR_CNT_W 9
`define ERR_WARN_LIMIT 9'h060
`define ERR_PASSIVE_LIMIT 9'h07f
`define ERR_BUSOFF_LIMIT 9'h0ff

`endif

//--- test/can_rx_flags_monitor.sv
// Purpose: Port-level checks for the receiver flag and enable block.
// Assumes: One clock domain with an active-low asynchronous reset.
// Notes: Bound to the design from the bench top file.
`default_nettype none
module can_rx_flags_monitor (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic init_request,
   input wire logic init_acknowledge,
   input wire logic fifo_shift,
   input wire logic buffer_release,
   input wire logic wakeup_event,
   input wire logic rx_request,
   input wire logic error_request,
   input wire logic wakeup_request,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // Two cycles in init mode give the soft reset time to land.
   sequence init_held;
      (init_request && init_acknowledge) [*2];
   endsequence
   sequence flag_write;
      reg_wr && reg_addr == 4'h0 && reg_wdata[0];
   endsequence
   init_quiet_a: assert property (init_held |-> !irq && !fifo_shift)
      else $error("request or shift seen in init mode");
   shift_once_a: assert property (fifo_shift |=> !fifo_shift)
      else $error("second shift while buffer full");
   release_cause_a: assert property (buffer_release |-> flag_write ##0 !init_request)
      else $error("release without a clearing write");
   release_clear_a: assert property (buffer_release |=> !rx_request)
      else $error("receive request survived a release");
   irq_sum_a: assert property (irq == (rx_request | error_request | wakeup_request))
      else $error("irq differs from its requests");
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside its slot");
   wake_cause_a: assert property ($rose(wakeup_request) |->
      $past(wakeup_event) || $past(reg_wr && reg_addr == 4'h1))
      else $error("wake request without a cause");
   rx_cause_a: assert property ($rose(rx_request) |->
      $past(fifo_shift) || $past(reg_wr && reg_addr == 4'h1))
      else $error("receive request without a cause");
   rx_hold_a: assert property (rx_request && !buffer_release && !init_request
      && !(reg_wr && reg_addr == 4'h1) |=> rx_request)
      else $error("receive request dropped without a clear");
endmodule // can_rx_flags_monitor
`default_nettype wire

//--- test/can_fifo_model.sv
// Purpose: Receive FIFO seen from the flag block, holding queued messages.
// Assumes: The bench loads a message count; one entry leaves per shift.
// Notes: Only the count is modelled, message contents are not needed here.
`default_nettype none
module can_fifo_model (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic fifo_shift,
   input wire logic [2:0] fill,
   input wire logic fill_en,
   output logic fifo_pending
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] count_r;
   // An entry moves to the foreground only on a shift, never on its own.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) count_r <= 3'h0;
      else if (fill_en) count_r <= fill;
      else if (fifo_shift && count_r != 3'h0) count_r <= count_r - 3'h1;
   end
   assign fifo_pending = (count_r != 3'h0);
endmodule // can_fifo_model
`default_nettype wire

//--- test/can_rx_flag_irq_enable_bench.sv
// Purpose: Directed scenarios for the receiver flag and enable block.
// Assumes: Flags at 0x0, enables at 0x1, read data one cycle after the strobe.
// Notes: Every task starts and ends just after a rising edge.
`default_nettype none
module can_rx_flag_irq_enable_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, fill_en = 1'b0;
   logic init_request = 1'b0, init_acknowledge = 1'b0, overrun_event = 1'b0;
   logic wakeup_event = 1'b0, fifo_pending, fifo_shift, buffer_release;
   logic rx_request, error_request, wakeup_request, irq;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata;
   logic [8:0] rx_err_count = 9'h000, tx_err_count = 9'h000;
   logic [2:0] fill = 3'h0;
   int n_tests = 0, n_mismatch = 0;
   can_rx_flag_irq_enable dut (.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .init_request, .init_acknowledge, .fifo_pending, .fifo_shift,
      .buffer_release, .overrun_event, .wakeup_event, .rx_err_count, .tx_err_count,
      .rx_request, .error_request, .wakeup_request, .irq);
   can_fifo_model fifo (.clk_sys, .resetn, .fifo_shift, .fill, .fill_en, .fifo_pending);
   always #5 clk_sys = ~clk_sys;
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // A write may carry an overrun pulse in the same cycle.
   task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic ov = 1'b0);
      reg_addr <= a;
      reg_wdata <= d;
      overrun_event <= ov;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      overrun_event <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
      logic [7:0] d;
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      chk(d, exp);
      @(posedge clk_sys);
   endtask
   task automatic step(input logic [7:0] en, input logic [8:0] rx, tx, input logic [7:0] exp);
      wr(4'h1, en);
      rx_err_count <= rx;
      tx_err_count <= tx;
      repeat (2) @(posedge clk_sys);
      rchk(4'h0, exp);
      #1 chk(8'(error_request), 8'(exp[6]));
      wr(4'h0, 8'h40);
   endtask
   task automatic t_rx();
      wr(4'h2, 8'hff);
      rchk(4'h2, 8'h00);
      fill <= 3'h2;
      fill_en <= 1'b1;
      @(posedge clk_sys);
      fill_en <= 1'b0;
      repeat (3) @(posedge clk_sys);
      rchk(4'h0, 8'h01);
      #1 chk(8'(fifo_shift | rx_request), 8'h00);
      wr(4'h1, 8'h01);
      #1 chk(8'(rx_request & irq), 8'h01);
      wr(4'h0, 8'h00);
      rchk(4'h0, 8'h01);
      wr(4'h0, 8'h01);
      rchk(4'h0, 8'h01);
      wr(4'h0, 8'h01);
      rchk(4'h0, 8'h00);
      $display("test rx done");
   endtask
   task automatic t_events();
      overrun_event <= 1'b1;
      @(posedge clk_sys);
      overrun_event <= 1'b0;
      rchk(4'h0, 8'h02);
      #1 chk(8'(error_request), 8'h00);
      wr(4'h1, 8'h02);
      #1 chk(8'(error_request), 8'h01);
      wr(4'h0, 8'h02, 1'b1);
      rchk(4'h0, 8'h02);
      wr(4'h0, 8'h02);
      rchk(4'h0, 8'h00);
      wr(4'h1, 8'h00);
      wakeup_event <= 1'b1;
      @(posedge clk_sys);
      wakeup_event <= 1'b0;
      #1 chk(8'(wakeup_request), 8'h00);
      wr(4'h1, 8'h80);
      #1 chk(8'(wakeup_request & irq), 8'h01);
      wr(4'h0, 8'h80);
      #1 chk(8'(wakeup_request), 8'h00);
      $display("test events done");
   endtask
   task automatic t_state();
      wr(4'h1, 8'h4c);
      tx_err_count <= 9'h080;
      repeat (2) @(posedge clk_sys);
      rchk(4'h0, 8'h48);
      tx_err_count <= 9'h000;
      repeat (2) @(posedge clk_sys);
      rchk(4'h0, 8'h48);
      wr(4'h0, 8'h40);
      rchk(4'h0, 8'h40);
      wr(4'h0, 8'h40);
      step(8'h4c, 9'h000, 9'h080, 8'h48);
      step(8'h44, 9'h000, 9'h064, 8'h04);
      step(8'h44, 9'h000, 9'h100, 8'h7c);
      step(8'h44, 9'h000, 9'h000, 8'h40);
      step(8'h60, 9'h080, 9'h000, 8'h60);
      step(8'h50, 9'h064, 9'h000, 8'h10);
      step(8'h70, 9'h000, 9'h000, 8'h40);
      step(8'h48, 9'h000, 9'h064, 8'h04);
      step(8'h48, 9'h000, 9'h080, 8'h48);
      $display("test state done");
   endtask
   task automatic t_init();
      wr(4'h1, 8'h8f);
      init_request <= 1'b1;
      init_acknowledge <= 1'b1;
      tx_err_count <= 9'h080;
      repeat (3) @(posedge clk_sys);
      rchk(4'h1, 8'h0c);
      wr(4'h1, 8'hff);
      rchk(4'h1, 8'h0c);
      rchk(4'h0, 8'h08);
      init_acknowledge <= 1'b0;
      wr(4'h1, 8'h83);
      rchk(4'h1, 8'h0c);
      init_request <= 1'b0;
      wr(4'h1, 8'h83);
      rchk(4'h1, 8'h83);
      $display("test init done");
   endtask
   task automatic stop_test();
      $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // The scenarios need well under a thousand cycles.
   initial begin
      #20000;
      n_mismatch++;
      stop_test();
   end
   initial begin
      repeat (12) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      rchk(4'h0, 8'h00);
      rchk(4'h1, 8'h00);
      t_rx();
      t_events();
      t_state();
      t_init();
      stop_test();
   end
endmodule // can_rx_flag_irq_enable_bench
bind can_rx_flag_irq_enable can_rx_flags_monitor mon (.clk_sys, .resetn, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .init_request, .init_acknowledge, .fifo_shift,
   .buffer_release, .wakeup_event, .rx_request, .error_request, .wakeup_request, .irq);
`default_nettype wire
